// *** core/reset_source_flag_logic.sv ***
// Functional notes
// - Low-voltage reset sets control bit 2; only software clears it.
// - Undefined voltage-select value sets control bit 1; only software clears.
// - Control bits 6 to 3 always read zero.
// - Watchdog time-out when running: full reset, time-out set, power-down kept.
// - Watchdog time-out asleep: clear PC and SP, set time-out and power-down.
// - Low-voltage reset when running keeps time-out and power-down flags.
// - Power-on reset clears time-out and power-down flags.
// - Power-on reset zeroes program counter and disables all interrupts.
// - Power-on reset clears the watchdog counter, which then counts at once.
// - Power-on reset turns all timer modules off.
// - Power-on reset makes every I/O pin an input.
// - Power-on reset points the stack pointer at stack top.
// - Invalid watchdog enable value sets control bit 0; only software clears.
// - Undefined voltage select: reset after delay, register back to 01010101.
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module reset_source_flag_logic
    import reset_flag_pkg::*;
#(
    parameter int SRESET_DELAY = SRESET_CYCLES,
    parameter int PULSE_LEN = PULSE_CYCLES
)
(
    // Clock and reset (nrst is the power-on reset)
    input wire logic sys_clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Monitors
    input wire logic lowVoltDetect,
    input wire logic wdogTimeout,
    input wire logic sleepMode,
    // Reset effects to the core
    output reset_flag_pkg::reset_effect_t effect,
    output logic [15:0] stackPointerInit,
    output logic idleSysclkKeepOn,
    output logic timeoutFlag,
    output logic powerDownFlag,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pins;
    logic [2:0] pinLevel;
    logic [2:0] pinPrev;
    logic lvEvent;
    logic wdEvent;
    logic slLevel;

    initial
    begin
        if (PULSE_LEN < 1 || PULSE_LEN > 255)
            $error("reset_source_flag_logic: PULSE_LEN out of range");
    end

    assign pins = {sleepMode, wdogTimeout, lowVoltDetect};

    // Three stages; a level counts once the last two agree
    for (genvar p = 0; p < 3; p++)
    begin : gSync
        logic [2:0] stages;
        always_ff @(posedge sys_clk)
        begin
            if (!nrst)
            begin
                stages <= '0;
                pinLevel[p] <= 1'b0;
                pinPrev[p] <= 1'b0;
            end
            else
            begin
                stages <= {stages[1:0], pins[p]};
                if (stages[1] == stages[2])
                    pinLevel[p] <= stages[2];
                pinPrev[p] <= pinLevel[p];
            end
        end
    end

    assign lvEvent = pinLevel[0] && !pinPrev[0];
    assign wdEvent = pinLevel[1] && !pinPrev[1];
    assign slLevel = pinLevel[2];

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    logic dataPhase;
    logic dataWrite;
    logic [7:0] dataAddr;
    logic wrEn;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            dataPhase <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr <= 8'h00;
        end
        else if (hready)
        begin
            dataPhase <= hsel && htrans[1];
            dataWrite <= hwrite;
            dataAddr <= haddr[7:0];
        end
    end

    assign wrEn = dataPhase && dataWrite;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic lvFlag;
    logic vselFlag;
    logic wdogFlag;
    logic [7:0] vsel;
    logic [4:0] wdogEn;
    logic [2:0] wdogSel;
    logic [IRQ_BITS-1:0] irqStatus;
    logic [IRQ_BITS-1:0] irqMask;
    logic vselBad;
    logic wdogBad;
    logic vselExpire;
    logic wdogExpire;
    logic [IRQ_BITS-1:0] events;
    logic wrCtrl;

    assign vselBad = !(vsel == VSEL_POR || vsel == VSEL_OK1 || vsel == VSEL_OK2
        || vsel == VSEL_OK3);
    assign wdogBad = !(wdogEn == WDOG_EN_POR || wdogEn == WDOG_EN_ALT);
    assign wrCtrl = wrEn && dataAddr == OFF_FLAG_CTRL;

    reset_delay #(.DELAY(SRESET_DELAY)) vselDelay (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(vselBad && !vselExpire),
        .busy(),
        .expire(vselExpire)
    );

    reset_delay #(.DELAY(SRESET_DELAY)) wdogDelay (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(wdogBad && !wdogExpire),
        .busy(),
        .expire(wdogExpire)
    );

    // Sticky cause flags: set beats clear
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            lvFlag <= 1'b0;
            vselFlag <= 1'b0;
            wdogFlag <= 1'b0;
        end
        else
        begin
            if (lvEvent)
                lvFlag <= 1'b1;
            else if (wrCtrl && !hwdata[BIT_LV_FLAG])
                lvFlag <= 1'b0;
            if (vselExpire)
                vselFlag <= 1'b1;
            else if (wrCtrl && !hwdata[BIT_VSEL_FLAG])
                vselFlag <= 1'b0;
            if (wdogExpire)
                wdogFlag <= 1'b1;
            else if (wrCtrl && !hwdata[BIT_WDOG_FLAG])
                wdogFlag <= 1'b0;
        end
    end

    // Voltage select returns to its power-on value on a bad-value reset
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            vsel <= VSEL_POR;
        else if (vselExpire)
            vsel <= VSEL_POR;
        else if (wrEn && dataAddr == OFF_VSEL)
            vsel <= hwdata[7:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wdogEn <= WDOG_EN_POR;
            wdogSel <= WDOG_SEL_POR;
        end
        else if (wdogExpire)
            wdogEn <= WDOG_EN_POR;
        else if (wrEn && dataAddr == OFF_WDOG_CTRL)
        begin
            wdogSel <= hwdata[2:0];
            wdogEn <= hwdata[7:3];
        end
    end

    // ------------------------------------------------------------
    // Status flags and reset effects
    // ------------------------------------------------------------
    logic fullReq;
    logic [7:0] pulseCount;
    reset_effect_t next_effect;

    assign fullReq = lvEvent || vselExpire || wdogExpire || (wdEvent && !slLevel);

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            timeoutFlag <= 1'b0;
            powerDownFlag <= 1'b0;
        end
        else if (wdEvent && slLevel)
        begin
            timeoutFlag <= 1'b1;
            powerDownFlag <= 1'b1;
        end
        else if (wdEvent)
            timeoutFlag <= 1'b1;
        // Low-voltage reset touches neither flag
    end

    always_comb
    begin
        next_effect = effect;
        if (fullReq)
        begin
            next_effect.fullReset = 1'b1;
            next_effect.clearPcSp = 1'b1;
            next_effect.irqDisable = 1'b1;
            next_effect.timersOff = 1'b1;
            next_effect.portsInput = 1'b1;
            next_effect.wdogClear = 1'b1;
        end
        else if (wdEvent && slLevel)
            next_effect.clearPcSp = 1'b1;
        else if (pulseCount == 8'h00)
            next_effect = '0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            // Power-on: pc zero, irqs off, wdog cleared, timers off, inputs
            effect <= '{clearPcSp: 1'b1, fullReset: 1'b1, irqDisable: 1'b1,
                timersOff: 1'b1, portsInput: 1'b1, wdogClear: 1'b1};
            pulseCount <= 8'(PULSE_LEN - 1);
        end
        else
        begin
            effect <= next_effect;
            if (fullReq || (wdEvent && slLevel))
                pulseCount <= 8'(PULSE_LEN - 1);
            else if (pulseCount != 8'h00)
                pulseCount <= pulseCount - 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        stackPointerInit <= STACK_TOP;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            idleSysclkKeepOn <= 1'b0;
        else if (wrCtrl)
            idleSysclkKeepOn <= hwdata[BIT_SYSCLK_KEEP];
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign events = {wdEvent, wdogExpire, vselExpire, lvEvent};

    for (genvar i = 0; i < IRQ_BITS; i++)
    begin : gIrq
        always_ff @(posedge sys_clk)
        begin
            if (!nrst)
                irqStatus[i] <= 1'b0;
            else if (events[i])
                irqStatus[i] <= 1'b1;
            else if (wrEn && dataAddr == OFF_IRQ_STATUS && hwdata[i])
                irqStatus[i] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            irqMask <= '0;
        else if (wrEn && dataAddr == OFF_IRQ_MASK)
            irqMask <= hwdata[IRQ_BITS-1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(irqStatus & irqMask);
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] next_hrdata;

    always_comb
    begin
        next_hrdata = 32'h0000_0000;
        case (haddr[7:0])
            OFF_FLAG_CTRL: next_hrdata = {24'h000000, idleSysclkKeepOn, 4'h0,
                lvFlag, vselFlag, wdogFlag};
            OFF_VSEL: next_hrdata = {24'h000000, vsel};
            OFF_WDOG_CTRL: next_hrdata = {24'h000000, wdogEn, wdogSel};
            OFF_STATUS: next_hrdata = {30'h0000_0000, timeoutFlag, powerDownFlag};
            OFF_IRQ_STATUS: next_hrdata = {28'h000_0000, irqStatus};
            OFF_IRQ_MASK: next_hrdata = {28'h000_0000, irqMask};
            OFF_RESET_OUT: next_hrdata = {26'h000_0000, effect};
            default: next_hrdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            hrdata <= 32'h0000_0000;
        else if (hready && hsel && htrans[1] && !hwrite)
            hrdata <= next_hrdata;
    end

    // Zero wait states, always OKAY
    always_ff @(posedge sys_clk)
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end

endmodule : reset_source_flag_logic

`default_nettype wire

// *** core/reset_flag_pkg.sv ***
package reset_flag_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_FLAG_CTRL = 8'h00;
    localparam logic [7:0] OFF_VSEL = 8'h04;
    localparam logic [7:0] OFF_WDOG_CTRL = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_RESET_OUT = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_SYSCLK_KEEP = 7;
    localparam int BIT_LV_FLAG = 2;
    localparam int BIT_VSEL_FLAG = 1;
    localparam int BIT_WDOG_FLAG = 0;
    localparam int BIT_TIMEOUT = 1;
    localparam int BIT_POWER_DOWN = 0;
    localparam int IRQ_BITS = 4;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] VSEL_POR = 8'h55;
    localparam logic [7:0] VSEL_OK1 = 8'h33;
    localparam logic [7:0] VSEL_OK2 = 8'h99;
    localparam logic [7:0] VSEL_OK3 = 8'hAA;
    localparam logic [4:0] WDOG_EN_POR = 5'h0A;
    localparam logic [4:0] WDOG_EN_ALT = 5'h15;
    localparam logic [2:0] WDOG_SEL_POR = 3'h7;
    localparam logic [15:0] STACK_TOP = 16'hFFFF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int SRESET_DELAY_US = 50;
    localparam int SRESET_CYCLES = SRESET_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int PULSE_CYCLES = 16;

    typedef enum logic [1:0] {
        CAUSE_LOW_VOLT,
        CAUSE_VSEL,
        CAUSE_WDOG_CTRL
    } cause_t;

    // Reset effects driven into the core
    typedef struct packed {
        logic clearPcSp;
        logic fullReset;
        logic irqDisable;
        logic timersOff;
        logic portsInput;
        logic wdogClear;
    } reset_effect_t;

endpackage : reset_flag_pkg

// *** core/reset_delay.sv ***
`timescale 1ns/1ps
`default_nettype none

module reset_delay
    import reset_flag_pkg::*;
#(
    parameter int DELAY = SRESET_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Trigger and expiry
    input wire logic start,
    output logic busy,
    output logic expire
);
    localparam int CW = $clog2(DELAY + 1);
    logic [CW-1:0] count;

    initial
    begin
        if (DELAY < 1)
            $error("reset_delay: DELAY must be at least 1");
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            count <= '0;
            busy <= 1'b0;
            expire <= 1'b0;
        end
        else
        begin
            expire <= 1'b0;
            if (!busy && start)
            begin
                busy <= 1'b1;
                count <= CW'(DELAY - 1);
            end
            else if (busy)
            begin
                if (count == '0)
                begin
                    busy <= 1'b0;
                    expire <= 1'b1;
                end
                else
                    count <= count - 1'b1;
            end
        end
    end

endmodule : reset_delay

`default_nettype wire

// *** verif/reset_source_flag_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module reset_source_flag_checker
    import reset_flag_pkg::*;
#(
    parameter int SRESET_DELAY = SRESET_CYCLES,
    parameter int PULSE_LEN = PULSE_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Reset outputs
    input wire reset_flag_pkg::reset_effect_t effect,
    input wire logic [15:0] stackPointerInit,
    input wire logic timeoutFlag,
    input wire logic powerDownFlag
);
    logic readCtrl;
    logic [7:0] runLen;

    default clocking cb @(posedge sys_clk);
    endclocking

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            readCtrl <= 1'b0;
        else
            readCtrl <= hsel && hready && htrans[1] && !hwrite && haddr == 32'(OFF_FLAG_CTRL);
    end

    // Length of the current full-reset pulse
    always_ff @(posedge sys_clk)
    begin
        if (!nrst || !effect.fullReset)
            runLen <= 8'h00;
        else if (runLen != 8'hFF)
            runLen <= runLen + 8'h01;
    end

    chk_bus_okay: assert property (disable iff (!nrst) hreadyout && !hresp)
        else $error("bus not ready or not okay");
    chk_por_flags: assert property (!nrst |=> !timeoutFlag && !powerDownFlag)
        else $error("status flags not cleared by power-on reset");
    chk_por_effect: assert property (!nrst |=> &effect)
        else $error("power-on effects not all asserted");
    chk_stack_top: assert property (disable iff (!nrst) stackPointerInit == STACK_TOP)
        else $error("stack pointer init not stack top");
    chk_flags_sticky: assert property (disable iff (!nrst)
        !$fell(timeoutFlag) && !$fell(powerDownFlag))
        else $error("status flag cleared without power-on reset");
    chk_pd_with_sleep: assert property (disable iff (!nrst)
        $rose(powerDownFlag) |-> timeoutFlag && effect.clearPcSp && !effect.fullReset)
        else $error("power-down flag set without sleep time-out");
    chk_to_full_reset: assert property (disable iff (!nrst)
        $rose(timeoutFlag) && !powerDownFlag |-> effect.fullReset)
        else $error("running time-out without full reset");
    chk_sleep_partial: assert property (disable iff (!nrst)
        effect.clearPcSp && !effect.fullReset |-> timeoutFlag && powerDownFlag)
        else $error("partial reset without both flags");
    chk_ctrl_unused: assert property (disable iff (!nrst) readCtrl |-> hrdata[6:3] == 4'h0)
        else $error("unused control bits not zero");
    chk_pulse_len: assert property (disable iff (!nrst) runLen <= 8'(PULSE_LEN + 1))
        else $error("full reset pulse too long");
endmodule : reset_source_flag_checker

bind reset_source_flag_logic reset_source_flag_checker #(
    .SRESET_DELAY(SRESET_DELAY), .PULSE_LEN(PULSE_LEN)
) reset_source_flag_checker_inst (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .effect(effect), .stackPointerInit(stackPointerInit), .timeoutFlag(timeoutFlag),
    .powerDownFlag(powerDownFlag)
);

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    import reset_flag_pkg::*;
    localparam int DLY = 4;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic lowVoltDetect = 1'b0;
    logic wdogTimeout = 1'b0;
    logic sleepMode = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    reset_effect_t effect;
    logic [15:0] stackPointerInit;
    logic idleSysclkKeepOn;
    logic timeoutFlag;
    logic powerDownFlag;
    logic irq;
    logic [31:0] okSel [4] = '{32'h33, 32'h99, 32'hAA, 32'h55};
    int miscompares = 0;
    int n_tests = 0;

    reset_source_flag_logic #(.SRESET_DELAY(DLY), .PULSE_LEN(2)) reset_source_flag_logic_inst (
        .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .lowVoltDetect(lowVoltDetect), .wdogTimeout(wdogTimeout), .sleepMode(sleepMode),
        .effect(effect), .stackPointerInit(stackPointerInit),
        .idleSysclkKeepOn(idleSysclkKeepOn), .timeoutFlag(timeoutFlag),
        .powerDownFlag(powerDownFlag), .irq(irq)
    );

    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic bus_cycle(input logic [7:0] a, input logic wr, input logic [31:0] d,
                             output logic [31:0] q);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus_cycle

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_cycle(a, 1'b1, d, q);
    endtask : bus_write

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus_cycle(a, 1'b0, 32'h0, q);
        check(what, q, exp);
    endtask : rd_check

    task automatic settle();
        repeat (10) @(posedge sys_clk);
    endtask : settle

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        check("power-on effects", {26'h0, effect}, 32'h3F);
        rd_check(OFF_FLAG_CTRL, 32'h0, "ctrl after reset");
        rd_check(OFF_STATUS, 32'h0, "status after reset");
        check("stack top", {16'h0, stackPointerInit}, {16'h0, STACK_TOP});
        $display("reset test done");
        lowVoltDetect <= 1'b1;
        settle();
        rd_check(OFF_FLAG_CTRL, 32'h4, "low-voltage flag");
        rd_check(OFF_STATUS, 32'h0, "status kept");
        rd_check(OFF_IRQ_STATUS, 32'h1, "irq status");
        check("irq masked", {31'h0, irq}, 32'h0);
        bus_write(OFF_IRQ_MASK, 32'hF);
        settle();
        check("irq raised", {31'h0, irq}, 32'h1);
        bus_write(OFF_IRQ_STATUS, 32'h1);
        settle();
        check("irq cleared", {31'h0, irq}, 32'h0);
        lowVoltDetect <= 1'b0;
        bus_write(OFF_FLAG_CTRL, 32'hFF);
        rd_check(OFF_FLAG_CTRL, 32'h84, "ctrl ones");
        check("keep-on pin", {31'h0, idleSysclkKeepOn}, 32'h1);
        bus_write(OFF_FLAG_CTRL, 32'h0);
        rd_check(OFF_FLAG_CTRL, 32'h0, "ctrl cleared");
        $display("low-voltage test done");
        wdogTimeout <= 1'b1;
        settle();
        rd_check(OFF_STATUS, 32'h2, "time-out running");
        wdogTimeout <= 1'b0;
        sleepMode <= 1'b1;
        settle();
        wdogTimeout <= 1'b1;
        settle();
        rd_check(OFF_STATUS, 32'h3, "time-out asleep");
        check("flag ports", {30'h0, timeoutFlag, powerDownFlag}, 32'h3);
        wdogTimeout <= 1'b0;
        sleepMode <= 1'b0;
        $display("watchdog test done");
        foreach (okSel[i])
        begin
            bus_write(OFF_VSEL, okSel[i]);
            rd_check(OFF_VSEL, okSel[i], "legal select");
        end
        settle();
        rd_check(OFF_FLAG_CTRL, 32'h0, "no select flag");
        bus_write(OFF_VSEL, 32'h12);
        repeat (DLY + 4) @(posedge sys_clk);
        rd_check(OFF_FLAG_CTRL, 32'h2, "select flag");
        rd_check(OFF_VSEL, {24'h0, VSEL_POR}, "select restored");
        bus_write(OFF_WDOG_CTRL, {24'h0, WDOG_EN_ALT, 3'h2});
        settle();
        rd_check(OFF_FLAG_CTRL, 32'h2, "legal enable");
        bus_write(OFF_WDOG_CTRL, 32'h1A);
        settle();
        rd_check(OFF_FLAG_CTRL, 32'h3, "enable flag");
        rd_check(OFF_WDOG_CTRL, {24'h0, WDOG_EN_POR, 3'h2}, "enable restored");
        bus_write(8'h40, 32'hFF);
        rd_check(8'h40, 32'h0, "unmapped");
        $display("select test done");
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        check("second reset effects", {26'h0, effect}, 32'h3F);
        rd_check(OFF_STATUS, 32'h0, "status after second reset");
        rd_check(OFF_FLAG_CTRL, 32'h0, "ctrl after second reset");
        $display("second reset test done");
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
